// ### sms_cfg.svh
/*
 Constants of the register bank with external data move stretch control:
 register indices, reset values, field positions, bus codes and timing.
 Assumes inclusion by the package and the bank module by bare name.
*/
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH

// ==========================================================================
// Register indices (byte address on the bus is four times the index)
`define IDX_PORT0          9'h080
`define IDX_STACK_PTR      9'h081
`define IDX_DPTR0_LOW      9'h082
`define IDX_DPTR0_HIGH     9'h083
`define IDX_DPTR1_LOW      9'h084
`define IDX_DPTR1_HIGH     9'h085
`define IDX_PTR_SELECT     9'h086
`define IDX_POWER_CTRL     9'h087
`define IDX_TIMER01_CTRL   9'h088
`define IDX_TIMER01_MODE   9'h089
`define IDX_TIMER0_LOW     9'h08a
`define IDX_TIMER1_LOW     9'h08b
`define IDX_TIMER0_HIGH    9'h08c
`define IDX_TIMER1_HIGH    9'h08d
`define IDX_CLK_STRETCH    9'h08e
`define IDX_PORT1          9'h090
`define IDX_SERIAL_CTRL    9'h098
`define IDX_SERIAL_BUF     9'h099
`define IDX_PORT2          9'h0a0
`define IDX_INT_ENABLE     9'h0a8
`define IDX_PORT3          9'h0b0
`define IDX_INT_PRIORITY   9'h0b8
`define IDX_CHIP_CONFIG    9'h0bf
`define IDX_PORT4          9'h0c0
`define IDX_TIMER2_CTRL    9'h0c8
`define IDX_MOVE_STATUS    9'h100

// ==========================================================================
// Reset values
`define RST_ZERO           8'h00
`define RST_PORT           8'hff
`define RST_STACK_PTR      8'h07
`define RST_POWER_CTRL     8'h30
`define RST_CLK_STRETCH    8'h01
`define RST_INT_PRIORITY   8'h80
`define RST_CHIP_CONFIG    8'h10

// ==========================================================================
// Fields and bus codes
`define SFR_BASE           9'h080
`define PTR_SEL_MASK       8'h01
`define STRETCH_LSB        0
`define STRETCH_MSB        2
`define TMR_CLK_LSB        3
`define TMR_CLK_MSB        5
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`define MOVE_BASE_CYCLES   4'h2
`define STROBE_MIN_CLKS    8'h02
`define STROBE_PER_CODE    8'h04

`endif

// ### sms_pkg.sv
/*
 Types of the register bank: move sequencer states and the bank state.
 Assumes sms_cfg.svh is on the include path.
*/
`include "sms_cfg.svh"

package sms_pkg;

	// ======================================================================
	// Sequencer states
	typedef enum logic [0:0] {
		MOVE_IDLE,
		MOVE_ACTIVE
	} sms_move_e;

	// ======================================================================
	// Whole state of the bank, registered in one place
	typedef struct packed {
		logic [127:0][7:0] sfr;
		logic              awHeld;
		logic [8:0]        awIdx;
		logic              wHeld;
		logic [7:0]        wData;
		logic              wLane0;
		logic              bValid;
		logic [1:0]        bResp;
		logic              rValid;
		logic [31:0]       rData;
		logic [1:0]        rResp;
		sms_move_e         mv;
		logic              mvWrite;
		logic [2:0]        mvCode;
		logic [7:0]        mvCnt;
		logic [15:0]       mvAddr;
		logic              rdOn;
		logic              wrOn;
		logic              mvDone;
		logic              lastBitAddr;
	} sms_state_s;

endpackage

// ### sms_sfr_bank.sv
/*
 Special function register bank with external data move stretch sequencer,
 reached over an AXI4-Lite slave port (32-bit data, one word per register).
 Assumes the processor core issues move requests synchronous to core_clk
 and that the bus master keeps AXI4-Lite valid/ready ordering.
*/
`timescale 1ns/1ps
`include "sms_cfg.svh"

// Operation
// - An external data move lasts stretch code plus two instruction cycles.
// - Strobe lasts two clocks at code zero, else four clocks per code.
// - Clock and stretch control resets to 01, giving code 001.
// - Clock and stretch control lives at 8E with timer clock selects.
// - Only listed registers decode; unused addresses have nothing behind.
// - Port latches 80,90,A0,B0,C0 reset to ones; C0 not bit-addressable.
// - Timer control at 88 bit-addressable; 88 through 8D reset zero.
// - Timer bytes ordered T0 low, T1 low, T0 high, T1 high.
// - Interrupt priority at B8, bit-addressable, resets to 80.
// - Second pointer bytes at 84 and 85, first at 82, 83; all zero.
// - Pointer select at 86 resets zero, first pointer active.
// - Serial control at 98 bit-addressable and buffer at 99, zero.
// - Interrupt enable A8 and timer 2 control C8 bit-addressable, zero.
// - Stretch code occupies bits 2 to 0, bit 2 most significant.
// - Select bit picks pointer; select bits 7 to 1 read zero.
module sms_sfr_bank
	import sms_pkg::*;
#(
	parameter int ADDR_W      = 12,
	parameter int CLKS_PER_IC = 4
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// AXI4-Lite write address and data
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// AXI4-Lite write response
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// AXI4-Lite read
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// External data move request from the core
	input  wire logic              moveStart,
	input  wire logic              moveWrite,
	output logic                   moveBusy,
	output logic                   moveDone,
	// External memory strobes and address
	output logic                   extReadStrobeN,
	output logic                   extWriteStrobeN,
	output logic [15:0]            extAddr,
	// Register contents used elsewhere in the chip
	output logic [15:0]            activeDataPointer,
	output logic [2:0]             timerFastClk,
	output logic [2:0]             stretchCode
);

	// ======================================================================
	// Decode helpers

	// True for every implemented register index
	// Gaps in the map stay unmapped so reads see zero there
	function automatic logic isMapped(input logic [8:0] idx);
		// listed slots only
		// Timer bytes: T0 low, T1 low, T0 high, T1 high at 8A..8D
		unique case (idx)
			`IDX_PORT0, `IDX_STACK_PTR, `IDX_DPTR0_LOW, `IDX_DPTR0_HIGH,
			`IDX_DPTR1_LOW, `IDX_DPTR1_HIGH, `IDX_PTR_SELECT,
			`IDX_POWER_CTRL, `IDX_TIMER01_CTRL, `IDX_TIMER01_MODE,
			`IDX_TIMER0_LOW, `IDX_TIMER1_LOW, `IDX_TIMER0_HIGH,
			`IDX_TIMER1_HIGH, `IDX_CLK_STRETCH, `IDX_PORT1,
			`IDX_SERIAL_CTRL, `IDX_SERIAL_BUF, `IDX_PORT2,
			`IDX_INT_ENABLE, `IDX_PORT3, `IDX_INT_PRIORITY,
			`IDX_CHIP_CONFIG, `IDX_PORT4, `IDX_TIMER2_CTRL:
				isMapped = 1'b1;
			default:
				isMapped = 1'b0;
		endcase
	endfunction

	// Registers the core may address bit by bit
	// Port 4 is left out on purpose: it is byte access only
	function automatic logic isBitAddr(input logic [8:0] idx);
		unique case (idx)
			`IDX_PORT0, `IDX_PORT1, `IDX_PORT2, `IDX_PORT3,
			`IDX_TIMER01_CTRL, `IDX_SERIAL_CTRL, `IDX_INT_ENABLE,
			`IDX_INT_PRIORITY, `IDX_TIMER2_CTRL:
				isBitAddr = 1'b1;
			default:
				isBitAddr = 1'b0;
		endcase
	endfunction

	// Reset byte of one register index
	// Chip configuration has don't-care bits; they reset to zero here
	function automatic logic [7:0] resetOf(input logic [8:0] idx);
		// reset values
		// Pointer select resets zero, so the first pointer is active
		unique case (idx)
			`IDX_PORT0, `IDX_PORT1, `IDX_PORT2, `IDX_PORT3, `IDX_PORT4:
				resetOf = `RST_PORT;
			`IDX_STACK_PTR:
				resetOf = `RST_STACK_PTR;
			`IDX_POWER_CTRL:
				resetOf = `RST_POWER_CTRL;
			`IDX_CLK_STRETCH:
				resetOf = `RST_CLK_STRETCH;
			`IDX_INT_PRIORITY:
				resetOf = `RST_INT_PRIORITY;
			`IDX_CHIP_CONFIG:
				resetOf = `RST_CHIP_CONFIG;
			default:
				resetOf = `RST_ZERO;
		endcase
	endfunction

	// Byte address to register index; the two lane bits are ignored
	function automatic logic [8:0] wordIdx(input logic [ADDR_W-1:0] a);
		wordIdx = a[10:2];
	endfunction

	// Whole move length in clocks
	function automatic logic [7:0] moveClks(input logic [2:0] code);
		moveClks = 8'(({1'b0, code} + `MOVE_BASE_CYCLES) * CLKS_PER_IC);
	endfunction

	// Strobe width in clocks; code zero is the short special case
	function automatic logic [7:0] strobeClks(input logic [2:0] code);
		if (code == 3'h0) begin
			strobeClks = `STROBE_MIN_CLKS;
		end else begin
			strobeClks = 8'({5'h00, code} * `STROBE_PER_CODE);
		end
	endfunction

	// Reset image of the whole bank; unmapped slots stay zero
	function automatic logic [127:0][7:0] sfrReset();
		logic [127:0][7:0] r;
		r = '0;
		for (int i = 0; i < 128; i++) begin
			r[i] = resetOf(9'(i) + `SFR_BASE);
		end
		sfrReset = r;
	endfunction

	// Reset image held as a constant so the reset branch loads constants only
	localparam logic [127:0][7:0] SFR_RESET = sfrReset();

	// Strobe opens one instruction cycle into the move.
	// With CLKS_PER_IC of 4 the longest strobe (28) ends at clock 32,
	// inside the 36 clocks of the longest move, so it never gets cut.
	// A smaller CLKS_PER_IC would clip long strobes at move end.
	localparam logic [7:0] STROBE_START = 8'(CLKS_PER_IC);

	// ======================================================================
	// State

	sms_state_s q;
	sms_state_s d;
	logic [8:0] wrIdx;
	logic [8:0] rdIdx;
	logic       doWrite;
	logic [7:0] nextCnt;
	logic [2:0] liveCode;
	logic [7:0] rdByte;

	assign wrIdx    = q.awIdx;
	assign rdIdx    = wordIdx(s_axi_araddr);
	assign doWrite  = q.awHeld && q.wHeld && !q.bValid;
	assign liveCode = q.sfr[7'(`IDX_CLK_STRETCH)][`STRETCH_MSB:`STRETCH_LSB];
	assign nextCnt  = q.mvCnt + 8'h01;

	// ======================================================================
	// Handshake outputs

	// One slot per channel: a new write waits until its response is
	// taken, which keeps the bank free of any write queue.
	assign s_axi_awready = !q.awHeld && !q.bValid;
	assign s_axi_wready  = !q.wHeld && !q.bValid;
	assign s_axi_arready = !q.rValid;

	// ======================================================================
	// Read data

	always_comb begin
		rdByte = `RST_ZERO;
		if (rdIdx[8:7] == 2'b01 && isMapped(rdIdx)) begin
			rdByte = q.sfr[rdIdx[6:0]];
		end
	end

	// ======================================================================
	// Next state

	always_comb begin
		d = q;
		d.mvDone = 1'b0;

		// Write channel capture, either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.awHeld = 1'b1;
			d.awIdx  = wordIdx(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.wHeld  = 1'b1;
			d.wData  = s_axi_wdata[7:0];
			d.wLane0 = s_axi_wstrb[0];
		end

		if (doWrite) begin
			d.awHeld = 1'b0;
			d.wHeld  = 1'b0;
			d.bValid = 1'b1;
			d.bResp  = (wrIdx[8] && wrIdx != `IDX_MOVE_STATUS) ?
				`RESP_SLVERR : `RESP_OKAY;
			if (q.wLane0 && wrIdx[8:7] == 2'b01 && isMapped(wrIdx)) begin
				d.sfr[wrIdx[6:0]] = q.wData;
				d.lastBitAddr = isBitAddr(wrIdx);
				if (wrIdx == `IDX_PTR_SELECT) begin
					d.sfr[wrIdx[6:0]] = q.wData & `PTR_SEL_MASK;
				end
			end
		end else if (q.bValid && s_axi_bready) begin
			d.bValid = 1'b0;
		end

		// Read channel: one cycle from address to data
		if (s_axi_arvalid && s_axi_arready) begin
			d.rValid = 1'b1;
			d.rResp  = `RESP_OKAY;
			d.rData  = {24'h000000, rdByte};
			if (rdIdx == `IDX_MOVE_STATUS) begin
				d.rData = {27'h0000000, q.lastBitAddr, q.mvCode,
					q.mv == MOVE_ACTIVE};
			end else if (rdIdx[8]) begin
				d.rResp = `RESP_SLVERR;
			end
		end else if (q.rValid && s_axi_rready) begin
			d.rValid = 1'b0;
		end

		// External data move sequencer
		// The code, direction and address are latched at start so a
		// register write during a move cannot reshape the strobe.
		// A start seen while busy is dropped without any sign.
		unique case (q.mv)
			MOVE_IDLE: begin
				if (moveStart) begin
					d.mvCode  = liveCode;
					d.mvWrite = moveWrite;
					d.mvAddr  = activeDataPointer;
					d.mvCnt   = 8'h00;
					d.mv      = MOVE_ACTIVE;
				end
			end
			MOVE_ACTIVE: begin
				d.mvCnt = nextCnt;
				d.rdOn = !q.mvWrite && nextCnt >= STROBE_START &&
					nextCnt < STROBE_START + strobeClks(q.mvCode);
				d.wrOn = q.mvWrite && nextCnt >= STROBE_START &&
					nextCnt < STROBE_START + strobeClks(q.mvCode);
				if (nextCnt == moveClks(q.mvCode)) begin
					d.mv     = MOVE_IDLE;
					d.mvDone = 1'b1;
					d.rdOn   = 1'b0;
					d.wrOn   = 1'b0;
				end
			end
		endcase
	end

	// ======================================================================
	// State register

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q             <= '0;
			q.sfr         <= SFR_RESET;
			q.mv          <= MOVE_IDLE;
			q.mvCode      <= 3'(`RST_CLK_STRETCH);
			q.bResp       <= `RESP_OKAY;
			q.rResp       <= `RESP_OKAY;
		end else begin
			q <= d;
		end
	end

	// ======================================================================
	// Outputs

	assign s_axi_bvalid = q.bValid;
	assign s_axi_bresp  = q.bResp;
	assign s_axi_rvalid = q.rValid;
	assign s_axi_rdata  = q.rData;
	assign s_axi_rresp  = q.rResp;

	// Every move output comes straight from a flip-flop of the state
	assign moveBusy        = q.mv == MOVE_ACTIVE;
	assign moveDone        = q.mvDone;
	assign extReadStrobeN  = !q.rdOn;
	assign extWriteStrobeN = !q.wrOn;
	assign extAddr         = q.mvAddr;
	assign stretchCode     = liveCode;
	// timer clock selects share the register
	assign timerFastClk =
		q.sfr[7'(`IDX_CLK_STRETCH)][`TMR_CLK_MSB:`TMR_CLK_LSB];

	// pointer choice by select bit
	// Combinational so a select write takes effect on the next move
	// without an extra register stage.
	always_comb begin
		if (q.sfr[7'(`IDX_PTR_SELECT)][0]) begin
			activeDataPointer = {q.sfr[7'(`IDX_DPTR1_HIGH)],
				q.sfr[7'(`IDX_DPTR1_LOW)]};
		end else begin
			activeDataPointer = {q.sfr[7'(`IDX_DPTR0_HIGH)],
				q.sfr[7'(`IDX_DPTR0_LOW)]};
		end
	end

endmodule

// ### sms_sfr_bank_chk.sv
/*
 Checker of the register bank: move length, strobe width, bus holds.
 Assumes it is bound to sms_sfr_bank and sees only its ports.
*/
`timescale 1ns/1ps
module sms_sfr_bank_chk #(
	parameter int CLKS_PER_IC = 4
) (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Register bus
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	// Move port
	input wire logic        moveStart,
	input wire logic        moveBusy,
	input wire logic        moveDone,
	input wire logic        extReadStrobeN,
	input wire logic        extWriteStrobeN,
	input wire logic [2:0]  stretchCode
);
	// ==========
	// Helper counters
	logic [2:0] code_q;
	logic [7:0] cyc_q;
	logic [7:0] low_q;
	logic       anyLow;
	assign anyLow = !extReadStrobeN || !extWriteStrobeN;
	// Code is latched at start so a write mid-move cannot skew the figure
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			code_q <= 3'h1;
			cyc_q <= 8'h00;
			low_q <= 8'h00;
		end else begin
			if (moveStart && !moveBusy) begin
				code_q <= stretchCode;
				cyc_q <= 8'h00;
			end else if (moveBusy) begin
				cyc_q <= cyc_q + 8'h01;
			end
			low_q <= anyLow ? low_q + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ==========
	// Assertions
	move_len_a: assert property (moveDone |->
		int'(cyc_q) == (int'(code_q) + 2) * CLKS_PER_IC)
		else $error("move length wrong");
	strobe_width_a: assert property ($fell(anyLow) |->
		int'(low_q) == (code_q == 3'h0 ? 2 : 4 * int'(code_q)))
		else $error("strobe width wrong");
	strobe_start_a: assert property ($rose(anyLow) |->
		int'(cyc_q) == CLKS_PER_IC) else $error("strobe start wrong");
	strobe_busy_a: assert property (anyLow |-> moveBusy)
		else $error("strobe outside move");
	done_pulse_a: assert property (moveDone |=> !moveDone)
		else $error("done too long");
	busy_start_a: assert property (moveStart && !moveBusy |=>
		moveBusy) else $error("move not started");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read late");
	r_upper_a: assert property (s_axi_rvalid |->
		s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
	cover property (moveDone && code_q == 3'h0);
	cover property (moveDone && code_q == 3'h7);
	cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

bind sms_sfr_bank sms_sfr_bank_chk #(.CLKS_PER_IC(CLKS_PER_IC)) u_chk (
	.core_clk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .s_axi_rresp, .moveStart, .moveBusy, .moveDone,
	.extReadStrobeN, .extWriteStrobeN, .stretchCode
);

// ### sms_core_model.sv
/*
 Processor core model: issues one move when asked, only while idle.
 Assumes requests come from the bench synchronous to core_clk.
*/
`timescale 1ns/1ps
module sms_core_model (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Requests from the bench
	input  wire logic req,
	input  wire logic wr,
	// Move port of the bank
	input  wire logic moveBusy,
	output logic      moveStart,
	output logic      moveWrite
);
	// A start pulse is one cycle; a request seen while busy is not kept
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			moveStart <= 1'b0;
			moveWrite <= 1'b0;
		end else if (moveStart) begin
			moveStart <= 1'b0;
		end else if (req && !moveBusy) begin
			moveStart <= 1'b1;
			moveWrite <= wr;
		end
	end
endmodule

// ### sfr_map_external_data_move_stretch_bench.sv
/*
 Bench of the register bank: reset map, pointers, moves, bad addresses.
 Assumes the checker is bound and the core clock runs at 50 MHz.
*/
`timescale 1ns/1ps
`include "sms_cfg.svh"
module sfr_map_external_data_move_stretch_bench;
	logic core_clk, rst, req, wr, moveStart, moveWrite, moveBusy, moveDone;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, extReadStrobeN, extWriteStrobeN;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [15:0] extAddr, activeDataPointer;
	logic [2:0]  timerFastClk, stretchCode;
	int          nMismatch, cmpCount;
	localparam logic [15:0] RST_TBL [27] = '{16'h80ff, 16'h8107, 16'h8200,
		16'h8300, 16'h8400, 16'h8500, 16'h8600, 16'h8730, 16'h8800, 16'h8900,
		16'h8a00, 16'h8b00, 16'h8c00, 16'h8d00, 16'h8e01, 16'h8f00, 16'h90ff,
		16'h9800, 16'h9900, 16'ha0ff, 16'ha800, 16'hb0ff, 16'hb880, 16'hbf10,
		16'hc0ff, 16'hc800, 16'h9a00};

	sms_sfr_bank dut (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .moveStart, .moveWrite, .moveBusy, .moveDone,
		.extReadStrobeN, .extWriteStrobeN, .extAddr, .activeDataPointer,
		.timerFastClk, .stretchCode);
	sms_core_model core (.core_clk, .rst, .req, .wr, .moveBusy, .moveStart,
		.moveWrite);

	// ==========
	// Shared tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmpCount++;
		if (s !== e) begin
			nMismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", cmpCount, nMismatch);
		if (nMismatch == 0 && cmpCount > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Ready is raised late on purpose so the slave must hold its answer
	task automatic axi_wr(input logic [8:0] i, input logic [7:0] d);
		s_axi_awaddr <= {1'b0, i, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid
			&& !s_axi_wready);
		repeat (2) @(posedge core_clk);
		s_axi_bready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [8:0] i, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= {1'b0, i, 2'b00};
		s_axi_arvalid <= 1'b1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge core_clk);
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic do_move(input logic w, input logic [2:0] c, m);
		time t0;
		req <= 1'b1;
		wr <= w;
		@(posedge core_clk);
		req <= 1'b0;
		while (!moveBusy) @(posedge core_clk);
		t0 = $time;
		if (m != c) axi_wr(`IDX_CLK_STRETCH, {5'h0, m});
		while (!moveDone) @(posedge core_clk);
		chk(32'(($time - t0) / 20), 32'((c + 4'h2) * 4));
		chk(extAddr, 32'h1234);
	endtask

	// ==========
	// Scenarios
	task automatic s_reset();
		for (int i = 0; i < 27; i++) begin
			axi_rd({1'b0, RST_TBL[i][15:8]}, rd, rr);
			chk(rd, {24'h0, RST_TBL[i][7:0]});
		end
	endtask
	task automatic s_ptr();
		axi_wr(`IDX_DPTR1_LOW, 8'h34);
		axi_wr(`IDX_DPTR1_HIGH, 8'h12);
		axi_wr(`IDX_DPTR0_LOW, 8'h78);
		axi_wr(`IDX_DPTR0_HIGH, 8'h56);
		chk(activeDataPointer, 32'h5678);
		axi_wr(`IDX_PTR_SELECT, 8'hff);
		axi_rd(`IDX_PTR_SELECT, rd, rr);
		chk(rd, 32'h1);
		chk(activeDataPointer, 32'h1234);
	endtask
	task automatic s_moves();
		for (logic [3:0] c = 0; c < 8; c++) begin
			axi_wr(`IDX_CLK_STRETCH, {2'b00, 3'h5, c[2:0]});
			chk(stretchCode, c[2:0]);
			chk(timerFastClk, 32'h5);
			do_move(c[0], c[2:0], c[2:0]);
		end
		axi_wr(`IDX_CLK_STRETCH, 8'h01);
		do_move(1'b0, 3'h1, 3'h7);
		do_move(1'b1, 3'h7, 3'h7);
	endtask
	task automatic s_errors();
		axi_rd(9'h101, rd, rr);
		chk(rr, 32'h2);
		chk(rd, 32'h0);
		axi_rd(`IDX_MOVE_STATUS, rd, rr);
		chk(rd, 32'he);
		axi_wr(9'h09a, 8'h5a);
		axi_rd(9'h09a, rd, rr);
		chk(rd, 32'h0);
		chk(rr, 32'h0);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		nMismatch++;
		end_of_test();
	end
	initial begin
		{rst, req, wr, s_axi_awvalid, s_axi_wvalid} = 5'b10000;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'b000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		nMismatch = 0;
		cmpCount = 0;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		s_reset();
		s_ptr();
		s_moves();
		s_errors();
		end_of_test();
	end
endmodule
